//--- bfi_exec.sv
// bfi_exec: executes stack, shift, rotate, bit and status flag operations.
// assumes operands arrive with the request from the same clock domain and
// the stack answers a read combinationally while stack_re is high.
`timescale 1ns/1ps
module bfi_exec (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic op_valid,
  input wire bfi_pkg::bfi_op_t op_code,
  input wire logic [bfi_pkg::BIT_W-1:0] op_bit,
  input wire bfi_pkg::bfi_word_t op_data,
  input wire bfi_pkg::bfi_word_t io_rdata,
  input wire bfi_pkg::bfi_word_t stack_rdata,
  output bfi_pkg::bfi_word_t rd_wdata,
  output logic rd_we,
  output bfi_pkg::bfi_word_t io_wdata,
  output logic io_we,
  output bfi_pkg::bfi_word_t stack_wdata,
  output logic stack_we,
  output logic stack_re,
  output bfi_pkg::bfi_word_t status,
  output logic busy,
  output logic done
);
  bfi_pkg::bfi_state_t state_q;
  bfi_pkg::bfi_state_t state_d;
  bfi_pkg::bfi_word_t status_q;
  bfi_pkg::bfi_word_t status_d;
  bfi_pkg::bfi_word_t rd_wdata_q;
  bfi_pkg::bfi_word_t rd_wdata_d;
  bfi_pkg::bfi_word_t io_wdata_q;
  bfi_pkg::bfi_word_t io_wdata_d;
  bfi_pkg::bfi_word_t stack_wdata_q;
  logic rd_we_q;
  logic rd_we_d;
  logic io_we_q;
  logic io_we_d;
  logic stack_we_q;
  logic stack_re_q;
  logic busy_q;
  logic done_q;
  logic accept;

  function automatic bfi_pkg::bfi_word_t bit_mask(
    input logic [bfi_pkg::BIT_W-1:0] idx
  );
    bit_mask = bfi_pkg::BIT_ONE << idx;
  endfunction

  assign accept = en && op_valid && (state_q == bfi_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // sequencing of two-cycle stack operations
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bfi_pkg::ST_IDLE:
      begin
        if (accept && op_code == bfi_pkg::OP_PUSH)
          state_d = bfi_pkg::ST_PUSH;
        else if (accept && op_code == bfi_pkg::OP_POP)
          state_d = bfi_pkg::ST_POP;
      end
      bfi_pkg::ST_PUSH: state_d = bfi_pkg::ST_IDLE;
      bfi_pkg::ST_POP: state_d = bfi_pkg::ST_IDLE;
      default: state_d = bfi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= bfi_pkg::ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (en)
    begin
      state_q <= state_d;
      busy_q <= (state_d != bfi_pkg::ST_IDLE);
      done_q <= (accept && op_code != bfi_pkg::OP_PUSH &&
                 op_code != bfi_pkg::OP_POP) ||
                (state_q != bfi_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack port
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stack_we_q <= 1'b0;
      stack_re_q <= 1'b0;
      stack_wdata_q <= bfi_pkg::WORD_ZERO;
    end
    else if (en)
    begin
      stack_we_q <= accept && op_code == bfi_pkg::OP_PUSH;
      stack_re_q <= accept && op_code == bfi_pkg::OP_POP;
      if (accept && op_code == bfi_pkg::OP_PUSH)
        stack_wdata_q <= op_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register, I/O and status results
  always_comb
  begin
    rd_wdata_d = rd_wdata_q;
    rd_we_d = 1'b0;
    io_wdata_d = io_wdata_q;
    io_we_d = 1'b0;
    status_d = status_q;
    if (state_q == bfi_pkg::ST_POP)
    begin
      rd_wdata_d = stack_rdata;
      rd_we_d = 1'b1;
    end
    else if (accept)
    begin
      case (op_code)
        bfi_pkg::OP_SET_IO_BIT:
        begin
          io_wdata_d = io_rdata | bit_mask(op_bit);
          io_we_d = 1'b1;
        end
        bfi_pkg::OP_CLEAR_IO_BIT:
        begin
          io_wdata_d = io_rdata & ~bit_mask(op_bit);
          io_we_d = 1'b1;
        end
        bfi_pkg::OP_LOGICAL_LEFT_SHIFT:
        begin
          rd_wdata_d = {op_data[bfi_pkg::MSB-1:0], 1'b0};
          rd_we_d = 1'b1;
          status_d[bfi_pkg::FLG_C] = op_data[bfi_pkg::MSB];
        end
        bfi_pkg::OP_LOGICAL_RIGHT_SHIFT:
        begin
          rd_wdata_d = {1'b0, op_data[bfi_pkg::MSB:1]};
          rd_we_d = 1'b1;
          status_d[bfi_pkg::FLG_C] = op_data[bfi_pkg::LSB];
        end
        bfi_pkg::OP_ROTATE_LEFT_CARRY:
        begin
          rd_wdata_d = {op_data[bfi_pkg::MSB-1:0],
                        status_q[bfi_pkg::FLG_C]};
          rd_we_d = 1'b1;
          status_d[bfi_pkg::FLG_C] = op_data[bfi_pkg::MSB];
        end
        bfi_pkg::OP_ROTATE_RIGHT_CARRY:
        begin
          rd_wdata_d = {status_q[bfi_pkg::FLG_C],
                        op_data[bfi_pkg::MSB:1]};
          rd_we_d = 1'b1;
          status_d[bfi_pkg::FLG_C] = op_data[bfi_pkg::LSB];
        end
        bfi_pkg::OP_ARITHMETIC_RIGHT_SHIFT:
        begin
          rd_wdata_d = {op_data[bfi_pkg::MSB],
                        op_data[bfi_pkg::MSB:1]};
          rd_we_d = 1'b1;
          status_d[bfi_pkg::FLG_C] = op_data[bfi_pkg::LSB];
        end
        bfi_pkg::OP_NIBBLE_SWAP:
        begin
          rd_wdata_d = {op_data[bfi_pkg::NIB-1:0],
                        op_data[bfi_pkg::MSB:bfi_pkg::NIB]};
          rd_we_d = 1'b1;
        end
        bfi_pkg::OP_GENERIC_FLAG_SET:
          status_d = status_q | bit_mask(op_bit);
        bfi_pkg::OP_GENERIC_FLAG_CLEAR:
          status_d = status_q & ~bit_mask(op_bit);
        bfi_pkg::OP_BIT_TO_TRANSFER_FLAG:
          status_d[bfi_pkg::FLG_T] = op_data[op_bit];
        bfi_pkg::OP_TRANSFER_FLAG_TO_BIT:
        begin
          rd_wdata_d = op_data;
          rd_wdata_d[op_bit] = status_q[bfi_pkg::FLG_T];
          rd_we_d = 1'b1;
        end
        bfi_pkg::OP_CARRY_SET: status_d[bfi_pkg::FLG_C] = 1'b1;
        bfi_pkg::OP_CARRY_CLEAR: status_d[bfi_pkg::FLG_C] = 1'b0;
        bfi_pkg::OP_NEGATIVE_SET: status_d[bfi_pkg::FLG_N] = 1'b1;
        bfi_pkg::OP_NEGATIVE_CLEAR:
          status_d[bfi_pkg::FLG_N] = 1'b0;
        bfi_pkg::OP_ZERO_SET: status_d[bfi_pkg::FLG_Z] = 1'b1;
        bfi_pkg::OP_ZERO_CLEAR: status_d[bfi_pkg::FLG_Z] = 1'b0;
        bfi_pkg::OP_GLOBAL_IRQ_ENABLE:
          status_d[bfi_pkg::FLG_I] = 1'b1;
        bfi_pkg::OP_GLOBAL_IRQ_DISABLE:
          status_d[bfi_pkg::FLG_I] = 1'b0;
        bfi_pkg::OP_SIGNED_SET: status_d[bfi_pkg::FLG_S] = 1'b1;
        bfi_pkg::OP_SIGNED_CLEAR: status_d[bfi_pkg::FLG_S] = 1'b0;
        bfi_pkg::OP_OVERFLOW_SET: status_d[bfi_pkg::FLG_V] = 1'b1;
        bfi_pkg::OP_OVERFLOW_CLEAR:
          status_d[bfi_pkg::FLG_V] = 1'b0;
        bfi_pkg::OP_TRANSFER_FLAG_SET:
          status_d[bfi_pkg::FLG_T] = 1'b1;
        bfi_pkg::OP_TRANSFER_FLAG_CLEAR:
          status_d[bfi_pkg::FLG_T] = 1'b0;
        bfi_pkg::OP_HALF_CARRY_SET:
          status_d[bfi_pkg::FLG_H] = 1'b1;
        default: status_d = status_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_wdata_q <= bfi_pkg::WORD_ZERO;
      rd_we_q <= 1'b0;
    end
    else if (en)
    begin
      rd_wdata_q <= rd_wdata_d;
      rd_we_q <= rd_we_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      io_wdata_q <= bfi_pkg::WORD_ZERO;
      io_we_q <= 1'b0;
    end
    else if (en)
    begin
      io_wdata_q <= io_wdata_d;
      io_we_q <= io_we_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      status_q <= bfi_pkg::STATUS_RST;
    else if (en)
      status_q <= status_d;
  end

  assign rd_wdata = rd_wdata_q;
  assign rd_we = rd_we_q;
  assign io_wdata = io_wdata_q;
  assign io_we = io_we_q;
  assign stack_wdata = stack_wdata_q;
  assign stack_we = stack_we_q;
  assign stack_re = stack_re_q;
  assign status = status_q;
  assign busy = busy_q;
  assign done = done_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  push_two_cycle_a: assert property (
    (accept && op_code == bfi_pkg::OP_PUSH) ##1 en |=>
      done_q && !stack_we_q && !busy_q &&
      stack_wdata_q == $past(op_data, 2))
    else $error("push did not finish in two cycles");

  pop_two_cycle_a: assert property (
    (accept && op_code == bfi_pkg::OP_POP) |=> (stack_re_q && !done_q) and
      (en |=> (rd_we_q && done_q && rd_wdata_q == $past(stack_rdata))))
    else $error("pop did not load the register in two cycles");

  set_io_bit_a: assert property (
    (accept && op_code == bfi_pkg::OP_SET_IO_BIT) |=>
      io_we_q && io_wdata_q == ($past(io_rdata) | bit_mask($past(op_bit))))
    else $error("set io bit result wrong");

  clear_io_bit_a: assert property (
    (accept && op_code == bfi_pkg::OP_CLEAR_IO_BIT) |=>
      io_we_q && io_wdata_q == ($past(io_rdata) & ~bit_mask($past(op_bit))))
    else $error("clear io bit result wrong");

  left_shift_a: assert property (
    (accept && op_code == bfi_pkg::OP_LOGICAL_LEFT_SHIFT) |=>
      rd_we_q && rd_wdata_q == ($past(op_data) << 1) &&
      status_q[bfi_pkg::FLG_C] == $past(op_data[bfi_pkg::MSB]))
    else $error("left shift result or carry wrong");

  rotate_right_a: assert property (
    (accept && op_code == bfi_pkg::OP_ROTATE_RIGHT_CARRY) |=>
      rd_wdata_q[bfi_pkg::MSB] == $past(status_q[bfi_pkg::FLG_C]) &&
      status_q[bfi_pkg::FLG_C] == $past(op_data[bfi_pkg::LSB]))
    else $error("rotate right through carry wrong");

  arith_shift_a: assert property (
    (accept && op_code == bfi_pkg::OP_ARITHMETIC_RIGHT_SHIFT) |=>
      $signed(rd_wdata_q) == ($signed($past(op_data)) >>> 1))
    else $error("arithmetic shift lost the sign");

  nibble_swap_a: assert property (
    (accept && op_code == bfi_pkg::OP_NIBBLE_SWAP) |=>
      {rd_wdata_q[bfi_pkg::NIB-1:0], rd_wdata_q[bfi_pkg::MSB:bfi_pkg::NIB]}
        == $past(op_data))
    else $error("nibble swap wrong");

  bit_load_a: assert property (
    (accept && op_code == bfi_pkg::OP_TRANSFER_FLAG_TO_BIT) |=>
      rd_we_q && rd_wdata_q[$past(op_bit)] == status_q[bfi_pkg::FLG_T])
    else $error("bit load did not copy transfer flag");

  carry_set_a: assert property (
    (accept && op_code == bfi_pkg::OP_CARRY_SET) |=>
      status_q[bfi_pkg::FLG_C] && done_q)
    else $error("carry set not done in one cycle");
endmodule // bfi_exec

//--- bfi_pkg.sv
// bfi_pkg: opcodes, states, status flag positions and widths for the
// bit and flag instruction execution unit.
// assumes the decoder hands over one opcode and operands per request.
//
// Behaviour
// - push writes the source register to the stack over two cycles.
// - pop loads the destination register from the stack over two cycles.
// - set I/O bit forces bit b of location P high, others kept.
// - clear I/O bit forces bit b of location P low, others kept.
// - logical left shift moves bit n to n+1, bit zero gets zero.
// - logical right shift moves bit n+1 to n, bit seven gets zero.
// - rotate left through carry: bit zero from carry, carry from bit seven.
// - rotate right through carry: bit seven from carry, carry from bit zero.
// - arithmetic right shift moves bits down, sign bit seven is kept.
// - nibble swap exchanges low and high four bits in one operation.
// - generic flag set and clear write one or zero to status bit s.
// - bit store copies source bit b into the transfer flag.
// - bit load copies transfer flag into destination bit b, others kept.
// - carry set and carry clear write one and zero, one cycle each.
// - negative flag set and clear write one and zero.
// - zero flag set and clear write one and zero.
// - interrupt enable sets global interrupt flag, disable clears it.
// - signed test flag set and clear write one and zero.
// - overflow flag set and clear write one and zero.
// - transfer flag set and clear write one and zero.
// - a dedicated instruction sets the half carry flag.
package bfi_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_W = 3;
  localparam int MSB = DATA_W - 1;
  localparam int LSB = 0;
  localparam int NIB = DATA_W / 2;
  typedef logic [DATA_W-1:0] bfi_word_t;
  localparam bfi_word_t STATUS_RST = 8'h00;
  localparam bfi_word_t WORD_ZERO = 8'h00;
  localparam bfi_word_t BIT_ONE = 8'h01;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_PUSH = 5'h01,
    OP_POP = 5'h02,
    OP_SET_IO_BIT = 5'h03,
    OP_CLEAR_IO_BIT = 5'h04,
    OP_LOGICAL_LEFT_SHIFT = 5'h05,
    OP_LOGICAL_RIGHT_SHIFT = 5'h06,
    OP_ROTATE_LEFT_CARRY = 5'h07,
    OP_ROTATE_RIGHT_CARRY = 5'h08,
    OP_ARITHMETIC_RIGHT_SHIFT = 5'h09,
    OP_NIBBLE_SWAP = 5'h0A,
    OP_GENERIC_FLAG_SET = 5'h0B,
    OP_GENERIC_FLAG_CLEAR = 5'h0C,
    OP_BIT_TO_TRANSFER_FLAG = 5'h0D,
    OP_TRANSFER_FLAG_TO_BIT = 5'h0E,
    OP_CARRY_SET = 5'h0F,
    OP_CARRY_CLEAR = 5'h10,
    OP_NEGATIVE_SET = 5'h11,
    OP_NEGATIVE_CLEAR = 5'h12,
    OP_ZERO_SET = 5'h13,
    OP_ZERO_CLEAR = 5'h14,
    OP_GLOBAL_IRQ_ENABLE = 5'h15,
    OP_GLOBAL_IRQ_DISABLE = 5'h16,
    OP_SIGNED_SET = 5'h17,
    OP_SIGNED_CLEAR = 5'h18,
    OP_OVERFLOW_SET = 5'h19,
    OP_OVERFLOW_CLEAR = 5'h1A,
    OP_TRANSFER_FLAG_SET = 5'h1B,
    OP_TRANSFER_FLAG_CLEAR = 5'h1C,
    OP_HALF_CARRY_SET = 5'h1D
  } bfi_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP = 2'b10
  } bfi_state_t;
endpackage

//--- bfi_exec_tb.sv
// bfi_exec_tb: self-checking bench for the bit and flag execution unit.
// assumes bfi_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module bfi_exec_tb;
  logic core_clk;
  logic nrst;
  logic en;
  logic op_valid;
  bfi_pkg::bfi_op_t op_code;
  logic [bfi_pkg::BIT_W-1:0] op_bit;
  bfi_pkg::bfi_word_t op_data;
  bfi_pkg::bfi_word_t io_rdata;
  bfi_pkg::bfi_word_t stack_rdata;
  bfi_pkg::bfi_word_t rd_wdata;
  logic rd_we;
  bfi_pkg::bfi_word_t io_wdata;
  logic io_we;
  bfi_pkg::bfi_word_t stack_wdata;
  logic stack_we;
  logic stack_re;
  bfi_pkg::bfi_word_t status;
  logic busy;
  logic done;
  int fails;
  int num_checks;
  bfi_pkg::bfi_word_t exp_st;

  bfi_exec i_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .en(en),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_bit(op_bit),
    .op_data(op_data),
    .io_rdata(io_rdata),
    .stack_rdata(stack_rdata),
    .rd_wdata(rd_wdata),
    .rd_we(rd_we),
    .io_wdata(io_wdata),
    .io_we(io_we),
    .stack_wdata(stack_wdata),
    .stack_we(stack_we),
    .stack_re(stack_re),
    .status(status),
    .busy(busy),
    .done(done)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input bfi_pkg::bfi_word_t seen,
                       input bfi_pkg::bfi_word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one request, taken at the next edge, done checked just after that same edge
  task automatic exec1(input bfi_pkg::bfi_op_t op, input int b,
                       input bfi_pkg::bfi_word_t d,
                       input bfi_pkg::bfi_word_t io);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_bit <= b[2:0];
    op_data <= d;
    io_rdata <= io;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check({7'h00, done}, 8'h01);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic reset_and_nop;
    check(status, 8'h00);
    check({6'h00, busy, done}, 8'h00);
    exec1(bfi_pkg::OP_NOP, 0, 8'hff, 8'hff);
    check(status, exp_st);
  endtask

  // dedicated flag ops: codes run set, clear per flag, half carry set only
  task automatic flag_ops;
    int pos[8] = '{bfi_pkg::FLG_C, bfi_pkg::FLG_N, bfi_pkg::FLG_Z,
                   bfi_pkg::FLG_I, bfi_pkg::FLG_S, bfi_pkg::FLG_V,
                   bfi_pkg::FLG_T, bfi_pkg::FLG_H};
    int p;
    for (int k = 0; k < 15; k++)
    begin
      p = pos[k / 2];
      exp_st[p] = (k % 2 == 0);
      exec1(bfi_pkg::bfi_op_t'(5'h0f + k), 0, 8'h00, 8'h00);
      check(status, exp_st);
      check({7'h00, status[p]}, {7'h00, exp_st[p]});
      check({6'h00, busy, done}, 8'h01);
    end
  endtask

  task automatic generic_flags;
    for (int s = 0; s < 8; s++)
    begin
      exp_st[s] = 1'b1;
      exec1(bfi_pkg::OP_GENERIC_FLAG_SET, s, 8'h00, 8'h00);
      check(status, exp_st);
    end
    for (int s = 7; s >= 0; s--)
    begin
      exp_st[s] = 1'b0;
      exec1(bfi_pkg::OP_GENERIC_FLAG_CLEAR, s, 8'hff, 8'h00);
      check(status, exp_st);
    end
  endtask

  // shifts, rotates and swap over both carry inputs
  task automatic shifts;
    bfi_pkg::bfi_word_t d;
    bfi_pkg::bfi_word_t r;
    logic c;
    for (int k = 0; k < 24; k++)
    begin
      d = (k % 2) ? 8'h42 : 8'h81;
      c = k[1];
      exec1(c ? bfi_pkg::OP_CARRY_SET : bfi_pkg::OP_CARRY_CLEAR, 0,
            8'h00, 8'h00);
      exp_st[0] = c;
      case (k / 4)
        0: r = {d[6:0], 1'b0};
        1: r = {1'b0, d[7:1]};
        2: r = {d[6:0], c};
        3: r = {c, d[7:1]};
        4: r = {d[7], d[7:1]};
        default: r = {d[3:0], d[7:4]};
      endcase
      if (k / 4 == 0 || k / 4 == 2)
        exp_st[0] = d[7];
      else if (k / 4 != 5)
        exp_st[0] = d[0];
      exec1(bfi_pkg::bfi_op_t'(5'h05 + k / 4), 0, d, 8'h00);
      check({7'h00, rd_we}, 8'h01);
      check(rd_wdata, r);
      check(status, exp_st);
    end
  endtask

  task automatic io_bits;
    bfi_pkg::bfi_word_t m;
    for (int b = 0; b < 8; b++)
    begin
      m = 8'h01 << b;
      exec1(bfi_pkg::OP_SET_IO_BIT, b, 8'h00, 8'h5a);
      check({7'h00, io_we}, 8'h01);
      check(io_wdata, 8'h5a | m);
      exec1(bfi_pkg::OP_CLEAR_IO_BIT, b, 8'hff, 8'h5a);
      check(io_wdata, 8'h5a & ~m);
    end
  endtask

  task automatic bit_transfer;
    bfi_pkg::bfi_word_t d;
    for (int b = 0; b < 8; b++)
    begin
      d = 8'ha5;
      exp_st[bfi_pkg::FLG_T] = d[b];
      exec1(bfi_pkg::OP_BIT_TO_TRANSFER_FLAG, b, d, 8'h00);
      check(status, exp_st);
      d = {8{~exp_st[6]}};
      exec1(bfi_pkg::OP_TRANSFER_FLAG_TO_BIT, b, d, 8'h00);
      d[b] = exp_st[6];
      check(rd_wdata, d);
    end
  endtask

  // push with a request held while busy, then pop
  task automatic stack_ops;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= bfi_pkg::OP_PUSH;
    op_data <= 8'h3c;
    @(posedge core_clk);
    op_code <= bfi_pkg::OP_TRANSFER_FLAG_CLEAR;
    #1;
    check({5'h00, stack_we, busy, done}, 8'h06);
    check(stack_wdata, 8'h3c);
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check({5'h00, stack_we, busy, done}, 8'h01);
    check(status, exp_st);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= bfi_pkg::OP_POP;
    stack_rdata <= 8'hc3;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check({6'h00, stack_re, busy}, 8'h03);
    @(posedge core_clk);
    stack_rdata <= 8'h3c;
    #1;
    check({5'h00, stack_re, rd_we, done}, 8'h03);
    check(rd_wdata, 8'hc3);
  endtask

  task automatic freeze;
    exec1(bfi_pkg::OP_CARRY_CLEAR, 0, 8'h00, 8'h00);
    exp_st[0] = 1'b0;
    @(posedge core_clk);
    en <= 1'b0;
    op_valid <= 1'b1;
    op_code <= bfi_pkg::OP_CARRY_SET;
    repeat (3) @(posedge core_clk);
    #1;
    check({7'h00, done}, 8'h00);
    check(status, exp_st);
    @(posedge core_clk);
    en <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    exp_st[0] = 1'b1;
    check({7'h00, done}, 8'h01);
    check(status, exp_st);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    en = 1'b1;
    op_valid = 1'b0;
    op_code = bfi_pkg::OP_NOP;
    op_bit = '0;
    op_data = 8'h00;
    io_rdata = 8'h00;
    stack_rdata = 8'h3c;
    exp_st = 8'h00;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    reset_and_nop();
    flag_ops();
    generic_flags();
    shifts();
    io_bits();
    bit_transfer();
    stack_ops();
    freeze();
    report_and_stop();
  end
endmodule // bfi_exec_tb
